/* wcq_config_table.sv */
`timescale 1ns/1ps
`include "wcq_defs.svh"
// Behaviour
// - queue n entry sits at table offset plus n times entry size
// - capability output reports how many work queues exist
// - entry spans two to the power of size code plus five bytes
// - aligned 1, 2, 4 and 8 byte accesses all accepted
// - writes to fields that are currently read-only are dropped
// - mode-support field is read-only always
// - threshold and occupancy interrupt enable writable when config or mode supported
// - queue-disabled-only fields lock while the queue is enabled
// - zero-size queue is inactive and refuses enable
// - fields other than size ignored for an inactive queue
// - enable request runs a consistency check first
// - size is a 16-bit count in bits 15:0, upper bits reserved
// - limited portal on a non-dedicated queue retries at occupancy at or above capped threshold
module wcq_config_table
    import wcq_pkg::*;
#(
    parameter int           NQ         = `WCQ_NUM_WQ,
    parameter int           AW         = 20,
    parameter logic [3:0]   SIZE_CODE  = `WCQ_CFG_SIZE_CODE,
    parameter logic [19:0]  TBL_OFF    = `WCQ_TABLE_OFFSET,
    parameter logic [15:0]  TOTAL_SIZE = `WCQ_TOTAL_SIZE,
    parameter int           QW         = (NQ > 1) ? $clog2(NQ) : 1
)
(
    // clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_srst,
    // memory-mapped access
    input  wire logic            i_req,
    input  wire logic            i_wr,
    input  wire logic [AW-1:0]   i_addr,
    input  wire logic [1:0]      i_size,
    input  wire logic [63:0]     i_wdata,
    output logic                 o_ack,
    output logic                 o_acc_err,
    output logic [63:0]          o_rdata,
    // device state and capabilities
    input  wire logic            i_dev_enabled,
    input  wire logic            i_cfg_support,
    input  wire logic [NQ-1:0]   i_mode_support,
    // queue enable control
    input  wire logic [NQ-1:0]   i_wq_en_req,
    input  wire logic [NQ-1:0]   i_wq_dis_req,
    output logic [NQ-1:0]        o_wq_enabled,
    output logic [NQ-1:0]        o_wq_en_err,
    // capability report
    output logic [AW-1:0]        o_table_offset,
    output logic [7:0]           o_num_wq,
    output logic [3:0]           o_cfg_size_code,
    output logic [15:0]          o_total_size,
    // limited portal submission check
    input  wire logic            i_lp_req,
    input  wire logic [QW-1:0]   i_lp_wq,
    input  wire logic [15:0]     i_lp_occupancy,
    output logic                 o_lp_done,
    output logic                 o_lp_retry
);
    localparam int ELOG = int'(SIZE_CODE) + `WCQ_ENTRY_LOG2_BASE;
    localparam int DWW  = ELOG - 2;

    // ------------------------------------------------------------------------
    // storage and helpers
    // ------------------------------------------------------------------------
    wcq_dw_t           cfg_ff  [NQ][`WCQ_NUM_DW];
    wcq_dw_t           nxt_cfg [NQ][`WCQ_NUM_DW];
    wcq_dw_t           img     [NQ][8];
    logic [NQ-1:0]     en_ff;
    logic [NQ-1:0]     nxt_en;
    logic [NQ-1:0]     err_ff;
    logic [NQ-1:0]     nxt_err;
    logic [NQ-1:0]     we_size;
    logic [NQ-1:0]     we_thr;
    logic [NQ-1:0]     we_dis;
    logic [NQ-1:0]     we_misc;
    logic [NQ-1:0]     we_oie;
    logic [NQ-1:0]     we_olim;

    function automatic wcq_dw_t bexp(input logic [3:0] b);
        bexp = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction

    function automatic wcq_dw_t cls_mask(input int k, input logic ws, input logic wt,
                                         input logic wd, input logic wm,
                                         input logic wo, input logic wl);
        case (k)
            `WCQ_DW_SIZE:  cls_mask = ws ? `WCQ_MSK_SIZE : 32'h0;
            `WCQ_DW_THR:   cls_mask = wt ? `WCQ_MSK_THR : 32'h0;
            `WCQ_DW_MODE:  cls_mask = (wd ? `WCQ_MSK_DW2_DIS : 32'h0)
                                    | (wm ? `WCQ_MSK_DW2_MISC : 32'h0);
            `WCQ_DW_PASID: cls_mask = wd ? `WCQ_MSK_DW3_DIS : 32'h0;
            `WCQ_DW_OCC:   cls_mask = (wl ? `WCQ_MSK_DW4_OLIM : 32'h0)
                                    | (wo ? `WCQ_MSK_DW4_OIE : 32'h0);
            `WCQ_DW_OCCH:  cls_mask = wd ? `WCQ_MSK_DW5_DIS : 32'h0;
            `WCQ_DW_MISC:  cls_mask = wm ? `WCQ_MSK_DW6_MISC : 32'h0;
            default:       cls_mask = 32'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    logic [AW-1:0]  rel;
    logic           in_tbl;
    logic           aligned;
    logic [QW-1:0]  sel_q;
    logic [DWW-1:0] dw_lo;
    logic [DWW-1:0] dw_hi;
    logic [7:0]     be8;
    logic [2:0]     amask;
    logic           acc_ok;
    logic           wr_go;

    always_comb begin
        rel    = i_addr - AW'(TBL_OFF);
        in_tbl = (i_addr >= AW'(TBL_OFF)) && ((rel >> ELOG) < AW'(NQ));
        sel_q  = rel[ELOG+QW-1:ELOG];
        dw_lo  = {rel[ELOG-1:3], 1'b0};
        dw_hi  = {rel[ELOG-1:3], 1'b1};
        unique case (i_size)
            2'h0: begin be8 = 8'h01; amask = 3'h0; end
            2'h1: begin be8 = 8'h03; amask = 3'h1; end
            2'h2: begin be8 = 8'h0f; amask = 3'h3; end
            2'h3: begin be8 = 8'hff; amask = 3'h7; end
        endcase
        be8     = 8'(be8 << i_addr[2:0]);
        aligned = (i_addr[2:0] & amask) == 3'h0;
        acc_ok  = i_req && in_tbl && aligned;
        wr_go   = acc_ok && i_wr;
    end

    function automatic wcq_dw_t rd_img(input logic [QW-1:0] q, input logic [DWW-1:0] k);
        rd_img = ((k >> 3) == '0) ? img[q][k[2:0]] : 32'h0;
    endfunction

    // ------------------------------------------------------------------------
    // per-queue entry storage and enable check
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < NQ; g++) begin : g_wq
        logic wsel;

        wcq_field_perm u_perm (
            .i_cfg_support  (i_cfg_support),
            .i_mode_support (i_mode_support[g]),
            .i_dev_enabled  (i_dev_enabled),
            .i_wq_enabled   (en_ff[g]),
            .i_occ_int_en   (cfg_ff[g][`WCQ_DW_OCC][`WCQ_BIT_OIE]),
            .o_we_size      (we_size[g]),
            .o_we_thr       (we_thr[g]),
            .o_we_dis       (we_dis[g]),
            .o_we_misc      (we_misc[g]),
            .o_we_oie       (we_oie[g]),
            .o_we_olim      (we_olim[g])
        );

        for (genvar k = 0; k < 8; k++) begin : g_img
            if (k < `WCQ_NUM_DW) begin : g_st
                assign img[g][k] = cfg_ff[g][k];
            end else begin : g_stat
                assign img[g][k] = {29'h0, err_ff[g], en_ff[g], i_mode_support[g]};
            end
        end

        always_comb begin
            wcq_dw_t m;
            wcq_dw_t wd;
            m    = 32'h0;
            wd   = 32'h0;
            wsel = wr_go && (sel_q == QW'(g));
            for (int k = 0; k < `WCQ_NUM_DW; k++) begin
                m  = 32'h0;
                wd = 32'h0;
                if (wsel && (DWW'(k) == dw_lo)) begin
                    m  = bexp(be8[3:0]);
                    wd = i_wdata[31:0];
                end else if (wsel && (DWW'(k) == dw_hi)) begin
                    m  = bexp(be8[7:4]);
                    wd = i_wdata[63:32];
                end
                // read-only bits keep their value
                m = m & cls_mask(k, we_size[g], we_thr[g], we_dis[g],
                                 we_misc[g], we_oie[g], we_olim[g]);
                nxt_cfg[g][k] = (cfg_ff[g][k] & ~m) | (wd & m);
            end
        end

        always_comb begin
            nxt_en[g]  = en_ff[g];
            nxt_err[g] = err_ff[g];
            if (!i_dev_enabled || i_wq_dis_req[g]) begin
                nxt_en[g] = 1'b0;
            end else if (i_wq_en_req[g] && !en_ff[g]) begin
                // consistency check: a zero-size queue never enables
                if (cfg_ff[g][`WCQ_DW_SIZE][15:0] != 16'h0) begin
                    nxt_en[g]  = 1'b1;
                    nxt_err[g] = 1'b0;
                end else begin
                    nxt_err[g] = 1'b1;
                end
            end
        end

        always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
                for (int k = 0; k < `WCQ_NUM_DW; k++) begin
                    cfg_ff[g][k] <= `WCQ_CFG_RESET;
                end
                en_ff[g]  <= 1'b0;
                err_ff[g] <= 1'b0;
            end else begin
                cfg_ff[g] <= nxt_cfg[g];
                en_ff[g]  <= nxt_en[g];
                err_ff[g] <= nxt_err[g];
            end
        end
    end

    assign o_wq_enabled = en_ff;
    assign o_wq_en_err  = err_ff;

    // ------------------------------------------------------------------------
    // access answer
    // ------------------------------------------------------------------------
    logic        ack_ff;
    logic        nxt_ack;
    logic        aerr_ff;
    logic        nxt_aerr;
    logic [63:0] rdata_ff;
    logic [63:0] nxt_rdata;

    always_comb begin
        nxt_ack   = i_req;
        nxt_aerr  = i_req && !(in_tbl && aligned);
        nxt_rdata = 64'h0;
        if (acc_ok && !i_wr) begin
            nxt_rdata = {rd_img(sel_q, dw_hi), rd_img(sel_q, dw_lo)}
                      & {bexp(be8[7:4]), bexp(be8[3:0])};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack_ff   <= 1'b0;
            aerr_ff  <= 1'b0;
            rdata_ff <= 64'h0;
        end else begin
            ack_ff   <= nxt_ack;
            aerr_ff  <= nxt_aerr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_ack     = ack_ff;
    assign o_acc_err = aerr_ff;
    assign o_rdata   = rdata_ff;

    // ------------------------------------------------------------------------
    // capability report
    // ------------------------------------------------------------------------
    logic [AW-1:0] toff_ff;
    logic [7:0]    nwq_ff;
    logic [3:0]    csz_ff;
    logic [15:0]   tsz_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            toff_ff <= '0;
            nwq_ff  <= 8'h00;
            csz_ff  <= 4'h0;
            tsz_ff  <= 16'h0000;
        end else begin
            toff_ff <= AW'(TBL_OFF);
            nwq_ff  <= 8'(NQ);
            csz_ff  <= SIZE_CODE;
            tsz_ff  <= TOTAL_SIZE;
        end
    end

    assign o_table_offset  = toff_ff;
    assign o_num_wq        = nwq_ff;
    assign o_cfg_size_code = csz_ff;
    assign o_total_size    = tsz_ff;

    // ------------------------------------------------------------------------
    // limited portal threshold check
    // ------------------------------------------------------------------------
    logic     lpd_ff;
    logic     nxt_lpd;
    logic     lpr_ff;
    logic     nxt_lpr;
    wcq_cnt_t lp_sz;
    wcq_cnt_t lp_th;
    wcq_cnt_t lp_lim;

    always_comb begin
        lp_sz   = 16'h0;
        lp_th   = 16'h0;
        nxt_lpd = i_lp_req;
        nxt_lpr = 1'b0;
        if (int'(i_lp_wq) < NQ) begin
            lp_sz = cfg_ff[i_lp_wq][`WCQ_DW_SIZE][15:0];
            lp_th = cfg_ff[i_lp_wq][`WCQ_DW_THR][15:0];
        end
        lp_lim = (lp_th > lp_sz) ? lp_sz : lp_th;
        if (i_lp_req) begin
            if ((int'(i_lp_wq) >= NQ) || (lp_sz == 16'h0) || !en_ff[i_lp_wq]) begin
                nxt_lpr = 1'b1;
            end else if (!cfg_ff[i_lp_wq][`WCQ_DW_MODE][`WCQ_BIT_DEDICATED]) begin
                nxt_lpr = i_lp_occupancy >= lp_lim;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            lpd_ff <= 1'b0;
            lpr_ff <= 1'b0;
        end else begin
            lpd_ff <= nxt_lpd;
            lpr_ff <= nxt_lpr;
        end
    end

    assign o_lp_done  = lpd_ff;
    assign o_lp_retry = lpr_ff;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    a_size_locked: assert property (i_dev_enabled
                                    |=> $stable(cfg_ff[0][`WCQ_DW_SIZE]))
        else $error("size changed while device enabled");
    a_size_write: assert property (wr_go && sel_q == '0 && dw_lo == '0 && be8 == 8'h0f
                                   && i_cfg_support && !i_dev_enabled
                                   |=> cfg_ff[0][0] == {16'h0, $past(i_wdata[15:0])})
        else $error("size write not taken");
    a_entry_stride: assert property (i_req && i_wr && i_size == 2'h2
                                     && i_cfg_support && !i_dev_enabled
                                     && i_addr == AW'(TBL_OFF) + AW'(1 << ELOG)
                                     |=> cfg_ff[1][0][15:0] == $past(i_wdata[15:0]))
        else $error("queue one entry not at offset plus entry size");
    a_mode_sup_ro: assert property (acc_ok && !i_wr && sel_q == '0 && dw_hi == DWW'(7)
                                    && be8[4] |=> o_rdata[32] == $past(i_mode_support[0]))
        else $error("mode support read wrong");
    a_lock_enabled: assert property (en_ff[0] |=> cfg_ff[0][`WCQ_DW_PASID]
                                     == $past(cfg_ff[0][`WCQ_DW_PASID]))
        else $error("locked field changed while queue enabled");
    a_all_ro: assert property (!i_cfg_support && !i_mode_support[4]
                               |=> cfg_ff[4][`WCQ_DW_THR] == $past(cfg_ff[4][`WCQ_DW_THR]))
        else $error("field written without support");
    a_zero_refused: assert property (i_wq_en_req[1] && !i_wq_dis_req[1]
                                     && i_dev_enabled && !en_ff[1]
                                     && cfg_ff[1][0][15:0] == 16'h0
                                     |=> !en_ff[1] && err_ff[1] && o_wq_en_err[1])
        else $error("zero-size queue enabled");
    a_lp_inactive: assert property (i_lp_req && i_lp_wq == QW'(1)
                                    && cfg_ff[1][0][15:0] == 16'h0 |=> o_lp_done && o_lp_retry)
        else $error("inactive queue accepted limited portal work");
    a_lp_cap: assert property (i_lp_req && i_lp_wq == '0 && en_ff[0]
                               && !cfg_ff[0][`WCQ_DW_MODE][0] && cfg_ff[0][0][15:0] != 16'h0
                               && i_lp_occupancy >= cfg_ff[0][0][15:0] |=> o_lp_retry)
        else $error("threshold not capped at size");
    a_aligned_ok: assert property (i_req && in_tbl && i_size == 2'h3
                                   && i_addr[2:0] == 3'h0 |=> o_ack && !o_acc_err)
        else $error("aligned eight-byte access refused");
    a_cap_count: assert property (!$past(i_srst) |-> o_num_wq == 8'(NQ))
        else $error("queue count not reported");

    c_wr_size: cover property (wr_go && we_size[0] && sel_q == '0);
    c_enable: cover property (!en_ff[0] ##1 en_ff[0]);
    c_lp_retry: cover property (o_lp_done && o_lp_retry);
    c_misalign: cover property (o_acc_err);
endmodule

/* wcq_defs.svh */
`ifndef WCQ_DEFS_SVH
`define WCQ_DEFS_SVH

// ----------------------------------------------------------------------------
// capability and table placement
// ----------------------------------------------------------------------------
`define WCQ_TABLE_OFFSET    20'h00400
`define WCQ_NUM_WQ          8
`define WCQ_CFG_SIZE_CODE   4'h0
`define WCQ_ENTRY_LOG2_BASE 5
`define WCQ_TOTAL_SIZE      16'h0080

// ----------------------------------------------------------------------------
// dword positions inside one entry
// ----------------------------------------------------------------------------
`define WCQ_NUM_DW          7
`define WCQ_DW_SIZE         0
`define WCQ_DW_THR          1
`define WCQ_DW_MODE         2
`define WCQ_DW_PASID        3
`define WCQ_DW_OCC          4
`define WCQ_DW_OCCH         5
`define WCQ_DW_MISC         6
`define WCQ_DW_STAT         7

// ----------------------------------------------------------------------------
// field positions and writable masks per permission class
// ----------------------------------------------------------------------------
`define WCQ_BIT_DEDICATED   0
`define WCQ_BIT_OIE         31
`define WCQ_STAT_MODE_SUP   0
`define WCQ_STAT_ENABLED    1
`define WCQ_STAT_EN_ERR     2
`define WCQ_MSK_SIZE        32'h0000ffff
`define WCQ_MSK_THR         32'h0000ffff
`define WCQ_MSK_DW2_DIS     32'ha0000001
`define WCQ_MSK_DW2_MISC    32'h00000f02
`define WCQ_MSK_DW3_DIS     32'h000fffff
`define WCQ_MSK_DW4_OLIM    32'h0000ffff
`define WCQ_MSK_DW4_OIE     32'h80000000
`define WCQ_MSK_DW5_DIS     32'hffff0001
`define WCQ_MSK_DW6_MISC    32'h00010f1f
`define WCQ_CFG_RESET       32'h00000000

`endif

/* wcq_field_perm.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// per-queue write permission of each field class
// ----------------------------------------------------------------------------
module wcq_field_perm
    import wcq_pkg::*;
(
    // state that steers writability
    input  wire logic i_cfg_support,
    input  wire logic i_mode_support,
    input  wire logic i_dev_enabled,
    input  wire logic i_wq_enabled,
    input  wire logic i_occ_int_en,
    // write enables per class
    output logic      o_we_size,
    output logic      o_we_thr,
    output logic      o_we_dis,
    output logic      o_we_misc,
    output logic      o_we_oie,
    output logic      o_we_olim
);
    logic any_cfg;

    always_comb begin
        any_cfg   = i_cfg_support | i_mode_support;
        o_we_size = i_cfg_support & ~i_dev_enabled;
        o_we_thr  = any_cfg;
        o_we_oie  = any_cfg;
        o_we_dis  = any_cfg & ~i_wq_enabled;
        o_we_misc = i_cfg_support & ~i_wq_enabled;
        o_we_olim = any_cfg & ~i_occ_int_en;
    end
endmodule

/* wcq_pkg.sv */
package wcq_pkg;
    typedef logic [31:0] wcq_dw_t;
    typedef logic [15:0] wcq_cnt_t;
endpackage

/* work_queue_config_table_bench.sv */
`timescale 1ns/1ps
`include "wcq_defs.svh"
module work_queue_config_table_bench
    import wcq_pkg::*;
;
    // ------------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------------
    localparam int STRIDE = 1 << (`WCQ_ENTRY_LOG2_BASE + `WCQ_CFG_SIZE_CODE);
    logic        i_sys_clk      = 1'b0;
    logic        i_srst         = 1'b1;
    logic        i_req          = 1'b0;
    logic        i_wr           = 1'b0;
    logic [19:0] i_addr         = 20'h00000;
    logic [1:0]  i_size         = 2'h0;
    logic [63:0] i_wdata        = 64'h0;
    logic        i_dev_enabled  = 1'b0;
    logic        i_cfg_support  = 1'b1;
    logic [7:0]  i_mode_support = 8'h0f;
    logic [7:0]  i_wq_en_req    = 8'h00;
    logic [7:0]  i_wq_dis_req   = 8'h00;
    logic        i_lp_req       = 1'b0;
    logic [2:0]  i_lp_wq        = 3'h0;
    logic [15:0] i_lp_occupancy = 16'h0;
    logic        o_ack, o_acc_err, o_lp_done, o_lp_retry;
    logic [63:0] o_rdata;
    logic [7:0]  o_wq_enabled, o_wq_en_err, o_num_wq;
    logic [19:0] o_table_offset;
    logic [3:0]  o_cfg_size_code;
    logic [15:0] o_total_size, sz[8];
    logic [65:0] acc_q[$];
    logic        lp_q[$];
    logic [31:0] r = 32'ha1423b6b;
    int          err_total = 0;
    int          samples_checked = 0;

    wcq_config_table dut_u (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_req(i_req),
        .i_wr(i_wr), .i_addr(i_addr), .i_size(i_size), .i_wdata(i_wdata), .o_ack(o_ack),
        .o_acc_err(o_acc_err), .o_rdata(o_rdata), .i_dev_enabled(i_dev_enabled),
        .i_cfg_support(i_cfg_support), .i_mode_support(i_mode_support),
        .i_wq_en_req(i_wq_en_req), .i_wq_dis_req(i_wq_dis_req),
        .o_wq_enabled(o_wq_enabled), .o_wq_en_err(o_wq_en_err),
        .o_table_offset(o_table_offset), .o_num_wq(o_num_wq),
        .o_cfg_size_code(o_cfg_size_code), .o_total_size(o_total_size), .i_lp_req(i_lp_req),
        .i_lp_wq(i_lp_wq), .i_lp_occupancy(i_lp_occupancy), .o_lp_done(o_lp_done),
        .o_lp_retry(o_lp_retry));

    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [19:0] ba(input int q, input int off);
        return `WCQ_TABLE_OFFSET + 20'(q * STRIDE + off);
    endfunction

    task automatic chk(input logic [64:0] e, input logic [64:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_acc(input logic [64:0] e, input logic [64:0] g);
        chk(e, g);
    endtask

    task automatic chk_lp(input logic e, input logic g);
        chk(65'(e), 65'(g));
    endtask

    // data and expectation are right-aligned, moved onto their byte lanes here
    task automatic acc(input logic wr, input logic [19:0] a, input logic [1:0] sz_c,
                       input logic [63:0] d, input logic [63:0] e, input logic err);
        @(posedge i_sys_clk);
        #1;
        i_req   = 1'b1;
        i_wr    = wr;
        i_addr  = a;
        i_size  = sz_c;
        i_wdata = d << (8 * a[2:0]);
        acc_q.push_back({~wr, err, err ? 64'h0 : e << (8 * a[2:0])});
    endtask

    task automatic idle();
        @(posedge i_sys_clk);
        #1;
        i_req        = 1'b0;
        i_lp_req     = 1'b0;
        i_wq_en_req  = 8'h00;
        i_wq_dis_req = 8'h00;
    endtask

    task automatic pulse(input logic [7:0] en, input logic [7:0] dis);
        @(posedge i_sys_clk);
        #1;
        i_wq_en_req  = en;
        i_wq_dis_req = dis;
        idle();
    endtask

    task automatic lp(input logic [2:0] q, input logic [15:0] occ, input logic exp);
        @(posedge i_sys_clk);
        #1;
        i_lp_req       = 1'b1;
        i_lp_wq        = q;
        i_lp_occupancy = occ;
        lp_q.push_back(exp);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (o_ack === 1'b1) begin
            if (acc_q.size() == 0) begin
                chk_acc(65'h0, 65'h1);
            end else if (acc_q[0][65]) begin
                chk_acc(65'(acc_q.pop_front()), {o_acc_err, o_rdata});
            end else begin
                chk_acc(65'(acc_q.pop_front() >> 64), 65'(o_acc_err));
            end
        end
        if (o_lp_done === 1'b1) begin
            chk_lp(lp_q.size() ? lp_q.pop_front() : ~o_lp_retry, o_lp_retry);
        end
    end

    initial begin
        #200000;
        err_total++;
        close_out();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_sys_clk);
        #1;
        i_srst = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk(65'(o_table_offset), 65'(`WCQ_TABLE_OFFSET));
        chk(65'(o_num_wq), 65'(`WCQ_NUM_WQ));
        chk(65'(o_cfg_size_code), 65'(`WCQ_CFG_SIZE_CODE));
        chk(65'(o_total_size), 65'(`WCQ_TOTAL_SIZE));
        for (int q = 0; q < 8; q++) begin
            r = lfsr(r);
            sz[q] = 16'(r % 15) + 16'h1;
            acc(1, ba(q, 0), 2, {16'hbeef, sz[q]}, 0, 0);
            acc(0, ba(q, 0), 2, 0, 64'(sz[q]), 0);
            acc(1, ba(q, 28), 2, 64'hffffffff, 0, 0);
            acc(0, ba(q, 28), 2, 0, 64'(i_mode_support[q]), 0);
        end
        acc(1, ba(0, 0), 3, {32'h10, 32'h7}, 0, 0);
        acc(0, ba(0, 0), 3, 0, {32'h10, 32'h7}, 0);
        acc(1, ba(0, 5), 0, 64'h1, 0, 0);
        acc(0, ba(0, 4), 1, 0, 64'h0110, 0);
        acc(0, ba(0, 5), 1, 0, 0, 1);
        acc(0, ba(8, 0), 2, 0, 0, 1);
        acc(1, ba(1, 0), 2, 0, 0, 0);
        acc(1, ba(2, 8), 2, 64'h1, 0, 0);
        acc(0, ba(2, 8), 2, 0, 64'h1, 0);
        acc(1, ba(3, 16), 2, 64'h80000005, 0, 0);
        acc(1, ba(3, 16), 2, 64'h80000009, 0, 0);
        acc(0, ba(3, 16), 2, 0, 64'h80000005, 0);
        idle();
        i_dev_enabled = 1'b1;
        pulse(8'h03, 8'h00);
        chk(65'(o_wq_enabled), 65'h01);
        chk(65'(o_wq_en_err), 65'h02);
        acc(1, ba(0, 0), 2, 64'h3, 0, 0);
        acc(0, ba(0, 0), 2, 0, 64'h7, 0);
        acc(1, ba(0, 8), 2, 64'h1, 0, 0);
        acc(0, ba(0, 8), 2, 0, 64'h0, 0);
        acc(1, ba(0, 4), 2, 64'h4, 0, 0);
        acc(0, ba(0, 4), 2, 0, 64'h4, 0);
        idle();
        lp(0, 16'h3, 0);
        lp(0, 16'h4, 1);
        lp(1, 16'h0, 1);
        idle();
        acc(1, ba(0, 4), 2, 64'h20, 0, 0);
        idle();
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            lp(0, 16'(r % 16), (r % 16) >= 7);
        end
        idle();
        pulse(8'h04, 8'h00);
        lp(2, 16'hffff, 0);
        idle();
        i_cfg_support = 1'b0;
        acc(1, ba(0, 4), 2, 64'h9, 0, 0);
        acc(0, ba(0, 4), 2, 0, 64'h9, 0);
        acc(1, ba(4, 4), 2, 64'h5, 0, 0);
        acc(0, ba(4, 4), 2, 0, 64'h0, 0);
        acc(1, ba(4, 8), 2, 64'h1, 0, 0);
        acc(0, ba(4, 8), 2, 0, 64'h0, 0);
        idle();
        pulse(8'h00, 8'h01);
        chk(65'(o_wq_enabled), 65'h04);
        i_dev_enabled = 1'b0;
        @(posedge i_sys_clk);
        #1;
        chk(65'(o_wq_enabled), 65'h00);
        for (int i = 0; i < 20 && (acc_q.size() || lp_q.size()); i++) @(posedge i_sys_clk);
        if (acc_q.size() || lp_q.size()) err_total++;
        close_out();
    end
endmodule
